// ---- design/fev_fault_event_flag_bank.v ----
// Fault event flag bank: two read-only, clear-on-read fault flag registers
`include "fev_map.vh"

// Functional notes
// R1 - Flags A bit 7: battery current regulation enter/exit
// R2 - Flags A bit 3: discharge over-current entered
// R3 - Flags A bit 2: converter over-current entered
// R4 - Flags B bit 7: switching stopped, system short
// R5 - Flags B bit 6: switching stopped, system over-voltage
// R6 - Flags B bit 5: reverse supply stopped, bus high
// R7 - Flags B bit 4: reverse supply stopped, bus low
// R8 - Flags B bit 2: thermal shutdown rising threshold
// R9 - Flags A at 0x26, resets to zero
// R10 - Flags B at 0x27, zero reset, unused bits zero
// R11 - Flags latch until read, then clear
module fev_fault_event_flag_bank (
    input  wire                    clk_sys,
    input  wire                    rst,
    input  wire                    batt_current_reg_event,
    input  wire                    input_bus_overvolt_event,
    input  wire                    battery_overvolt_event,
    input  wire                    input_overcurrent_event,
    input  wire                    discharge_overcurrent_event,
    input  wire                    converter_overcurrent_event,
    input  wire                    second_input_overvolt_event,
    input  wire                    first_input_overvolt_event,
    input  wire                    system_rail_short_event,
    input  wire                    system_rail_overvolt_event,
    input  wire                    reverse_supply_overvolt_event,
    input  wire                    reverse_supply_undervolt_event,
    input  wire                    thermal_shutdown_event,
    input  wire                    rd_en,
    input  wire [`FEV_ADDR_W-1:0]  rd_addr,
    output reg  [`FEV_DATA_W-1:0]  rd_data,
    output reg                     rd_valid,
    output reg                     fault_pending
);

    wire [`FEV_COND_W-1:0] cond_level;
    wire [`FEV_COND_W-1:0] cond_rise;
    wire [`FEV_COND_W-1:0] cond_fall;

    reg  [`FEV_DATA_W-1:0] flags_a_reg;
    reg  [`FEV_DATA_W-1:0] flags_a_next;
    reg  [`FEV_DATA_W-1:0] flags_b_reg;
    reg  [`FEV_DATA_W-1:0] flags_b_next;
    reg  [`FEV_DATA_W-1:0] set_a;
    reg  [`FEV_DATA_W-1:0] set_b;
    reg  [`FEV_DATA_W-1:0] rd_data_next;
    reg                    rd_a;
    reg                    rd_b;

    function addr_hit;
        input [`FEV_ADDR_W-1:0] addr;
        input [`FEV_ADDR_W-1:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    assign cond_level[`FEV_C_BATT_CURRENT_REG] = batt_current_reg_event;
    assign cond_level[`FEV_C_INPUT_BUS_OV]     = input_bus_overvolt_event;
    assign cond_level[`FEV_C_BATTERY_OV]       = battery_overvolt_event;
    assign cond_level[`FEV_C_INPUT_OC]         = input_overcurrent_event;
    assign cond_level[`FEV_C_DISCHARGE_OC]     = discharge_overcurrent_event;
    assign cond_level[`FEV_C_CONVERTER_OC]     = converter_overcurrent_event;
    assign cond_level[`FEV_C_SECOND_INPUT_OV]  = second_input_overvolt_event;
    assign cond_level[`FEV_C_FIRST_INPUT_OV]   = first_input_overvolt_event;
    assign cond_level[`FEV_C_SYSTEM_SHORT]     = system_rail_short_event;
    assign cond_level[`FEV_C_SYSTEM_OV]        = system_rail_overvolt_event;
    assign cond_level[`FEV_C_REVERSE_OV]       = reverse_supply_overvolt_event;
    assign cond_level[`FEV_C_REVERSE_UV]       = reverse_supply_undervolt_event;
    assign cond_level[`FEV_C_THERMAL_SHUTDOWN] = thermal_shutdown_event;

    // Detector levels come from the analog side, outside this clock
    fev_sync_edge #(
        .W        (`FEV_COND_W)
    ) u_sync_edge (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .level_in (cond_level),
        .rise     (cond_rise),
        .fall     (cond_fall)
    );

    // Event pulses mapped onto flag positions
    always @* begin
        set_a = 8'h00;
        set_b = 8'h00;
        set_a[`FEV_A_BATT_CURRENT_REG] = cond_rise[`FEV_C_BATT_CURRENT_REG]
                                       | cond_fall[`FEV_C_BATT_CURRENT_REG]; // R1
        set_a[`FEV_A_INPUT_BUS_OV]     = cond_rise[`FEV_C_INPUT_BUS_OV];
        set_a[`FEV_A_BATTERY_OV]       = cond_rise[`FEV_C_BATTERY_OV];
        set_a[`FEV_A_INPUT_OC]         = cond_rise[`FEV_C_INPUT_OC];
        set_a[`FEV_A_DISCHARGE_OC]     = cond_rise[`FEV_C_DISCHARGE_OC]; // R2
        set_a[`FEV_A_CONVERTER_OC]     = cond_rise[`FEV_C_CONVERTER_OC]; // R3
        set_a[`FEV_A_SECOND_INPUT_OV]  = cond_rise[`FEV_C_SECOND_INPUT_OV];
        set_a[`FEV_A_FIRST_INPUT_OV]   = cond_rise[`FEV_C_FIRST_INPUT_OV];
        set_b[`FEV_B_SYSTEM_SHORT]     = cond_rise[`FEV_C_SYSTEM_SHORT]; // R4
        set_b[`FEV_B_SYSTEM_OV]        = cond_rise[`FEV_C_SYSTEM_OV]; // R5
        set_b[`FEV_B_REVERSE_OV]       = cond_rise[`FEV_C_REVERSE_OV]; // R6
        set_b[`FEV_B_REVERSE_UV]       = cond_rise[`FEV_C_REVERSE_UV]; // R7
        set_b[`FEV_B_THERMAL_SHUTDOWN] = cond_rise[`FEV_C_THERMAL_SHUTDOWN]; // R8
    end

    // Read decode
    always @* begin
        rd_a = rd_en & addr_hit(rd_addr, `FEV_OFFSET_FLAGS_A); // R9
        rd_b = rd_en & addr_hit(rd_addr, `FEV_OFFSET_FLAGS_B); // R10
        if (rd_a) begin
            rd_data_next = flags_a_reg;
        end else if (rd_b) begin
            rd_data_next = flags_b_reg & `FEV_B_USED_MASK; // R10
        end else begin
            rd_data_next = `FEV_READ_UNMAPPED;
        end
    end

    // Clear on read; an event in the read cycle still sets its flag
    always @* begin
        flags_a_next = (rd_a ? 8'h00 : flags_a_reg) | set_a; // R11
        flags_b_next = ((rd_b ? 8'h00 : flags_b_reg) | set_b) & `FEV_B_USED_MASK; // R11
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_a_reg   <= `FEV_RESET_FLAGS_A; // R9
            flags_b_reg   <= `FEV_RESET_FLAGS_B; // R10
            rd_data       <= 8'h00;
            rd_valid      <= 1'b0;
            fault_pending <= 1'b0;
        end else begin
            flags_a_reg   <= flags_a_next;
            flags_b_reg   <= flags_b_next;
            rd_data       <= rd_en ? rd_data_next : 8'h00;
            rd_valid      <= rd_en;
            fault_pending <= (|flags_a_next) | (|flags_b_next);
        end
    end

endmodule // fev_fault_event_flag_bank

// ---- design/fev_map.vh ----
// Offsets, field positions and reset values of the fault event flag bank
`ifndef FEV_MAP_VH
`define FEV_MAP_VH

`define FEV_ADDR_W              8
`define FEV_DATA_W              8

`define FEV_OFFSET_FLAGS_A      8'h26
`define FEV_OFFSET_FLAGS_B      8'h27

`define FEV_RESET_FLAGS_A       8'h00
`define FEV_RESET_FLAGS_B       8'h00
`define FEV_READ_UNMAPPED       8'h00

// Fault event flags A
`define FEV_A_BATT_CURRENT_REG  7
`define FEV_A_INPUT_BUS_OV      6
`define FEV_A_BATTERY_OV        5
`define FEV_A_INPUT_OC          4
`define FEV_A_DISCHARGE_OC      3
`define FEV_A_CONVERTER_OC      2
`define FEV_A_SECOND_INPUT_OV   1
`define FEV_A_FIRST_INPUT_OV    0

// Fault event flags B
`define FEV_B_SYSTEM_SHORT      7
`define FEV_B_SYSTEM_OV         6
`define FEV_B_REVERSE_OV        5
`define FEV_B_REVERSE_UV        4
`define FEV_B_THERMAL_SHUTDOWN  2
`define FEV_B_USED_MASK         8'hf4

// Detector condition vector layout
`define FEV_COND_W              13
`define FEV_C_BATT_CURRENT_REG  0
`define FEV_C_INPUT_BUS_OV      1
`define FEV_C_BATTERY_OV        2
`define FEV_C_INPUT_OC          3
`define FEV_C_DISCHARGE_OC      4
`define FEV_C_CONVERTER_OC      5
`define FEV_C_SECOND_INPUT_OV   6
`define FEV_C_FIRST_INPUT_OV    7
`define FEV_C_SYSTEM_SHORT      8
`define FEV_C_SYSTEM_OV         9
`define FEV_C_REVERSE_OV        10
`define FEV_C_REVERSE_UV        11
`define FEV_C_THERMAL_SHUTDOWN  12

`endif

// ---- design/fev_sync_edge.v ----
// Three-stage synchroniser with agreement filter and edge pulses
module fev_sync_edge #(
    parameter W = 13
) (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire [W-1:0] level_in,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] sync2_reg;
    reg [W-1:0] sync3_reg;
    reg [W-1:0] stable_reg;
    reg [W-1:0] stable_next;
    reg [W-1:0] stable_d_reg;

    integer i;

    // A bit only changes once stages two and three agree
    always @* begin
        stable_next = stable_reg;
        for (i = 0; i < W; i = i + 1) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
                stable_next[i] = sync3_reg[i];
            end
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_reg     <= {W{1'b0}};
            sync2_reg    <= {W{1'b0}};
            sync3_reg    <= {W{1'b0}};
            stable_reg   <= {W{1'b0}};
            stable_d_reg <= {W{1'b0}};
        end else begin
            meta_reg     <= level_in;
            sync2_reg    <= meta_reg;
            sync3_reg    <= sync2_reg;
            stable_reg   <= stable_next;
            stable_d_reg <= stable_reg;
        end
    end

    assign rise = stable_reg & ~stable_d_reg;
    assign fall = ~stable_reg & stable_d_reg;

endmodule // fev_sync_edge

// ---- tb/fev_bank_properties.sv ----
// Checker for the flag bank read port and event-to-flag timing
module fev_bank_properties (
    input wire       clk_sys,
    input wire       rst,
    input wire       rd_en,
    input wire       rd_valid,
    input wire       fault_pending,
    input wire       batt_current_reg_event,
    input wire       system_rail_short_event,
    input wire       thermal_shutdown_event,
    input wire [7:0] rd_addr,
    input wire [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_read_answered: assert property (rd_en |=> rd_valid)
        else $error("read request not answered next cycle");
    chk_no_spurious: assert property (!rd_en |=> !rd_valid)
        else $error("read answer without request");
    chk_idle_data: assert property (!rd_valid |-> rd_data == 8'h00)
        else $error("read data not zero while idle");
    chk_b_unused_zero: assert property (rd_valid && $past(rd_addr) == 8'h27 |-> (rd_data & 8'h0b) == 8'h00)
        else $error("unused flag bits read as one");
    chk_unmapped_zero: assert property (rd_valid && $past(rd_addr) != 8'h26 && $past(rd_addr) != 8'h27 |-> rd_data == 8'h00)
        else $error("unmapped read returned data");
    chk_none_pending: assert property (rd_en && !fault_pending |=> rd_data == 8'h00)
        else $error("flag read while nothing pending");
    chk_thermal_flag: assert property ($rose(thermal_shutdown_event) |-> ##5 fault_pending)
        else $error("thermal event did not raise a flag");
    chk_short_flag: assert property ($rose(system_rail_short_event) |-> ##5 fault_pending)
        else $error("system short did not raise a flag");
    chk_regulation_exit: assert property ($fell(batt_current_reg_event) |-> ##5 fault_pending)
        else $error("regulation exit did not raise a flag");
    cover property (rd_valid && rd_data != 8'h00);
    cover property ($rose(fault_pending));
    cover property (rd_en ##1 rd_en);
endmodule // fev_bank_properties

bind fev_fault_event_flag_bank fev_bank_properties chk (
    .clk_sys(clk_sys), .rst(rst), .rd_en(rd_en), .rd_valid(rd_valid),
    .fault_pending(fault_pending), .batt_current_reg_event(batt_current_reg_event),
    .system_rail_short_event(system_rail_short_event),
    .thermal_shutdown_event(thermal_shutdown_event), .rd_addr(rd_addr), .rd_data(rd_data)
);

// ---- tb/fev_host.sv ----
// Host model: issues register reads on the flag bank read port
module fev_host (
    input  wire        clk_sys,
    output logic       rd_en,
    output logic [7:0] rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rd_en = 1'b0;
    initial rd_addr = 8'h00;
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge clk_sys);
    endtask
    // Released address shows a changed value so stale reuse is caught
    task automatic idle;
        @(negedge clk_sys);
        rd_en = 1'b0;
        rd_addr = ~rd_addr;
    endtask
endmodule // fev_host

// ---- tb/fev_fault_event_flag_bank_bench.sv ----
// Self-checking bench for the fault event flag bank
module fev_fault_event_flag_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [12:0] ev = 13'h0000;
    wire         rd_en, rd_valid, fault_pending;
    wire  [7:0]  rd_addr, rd_data;
    logic [7:0]  exp_q[$];
    logic [7:0]  ua, m;
    int          n_errors = 0, compares = 0, cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    fev_host host (.clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr));
    fev_fault_event_flag_bank DUT (.clk_sys(clk_sys), .rst(rst),
        .batt_current_reg_event(ev[0]), .input_bus_overvolt_event(ev[1]),
        .battery_overvolt_event(ev[2]), .input_overcurrent_event(ev[3]),
        .discharge_overcurrent_event(ev[4]), .converter_overcurrent_event(ev[5]),
        .second_input_overvolt_event(ev[6]), .first_input_overvolt_event(ev[7]),
        .system_rail_short_event(ev[8]), .system_rail_overvolt_event(ev[9]),
        .reverse_supply_overvolt_event(ev[10]), .reverse_supply_undervolt_event(ev[11]),
        .thermal_shutdown_event(ev[12]), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .fault_pending(fault_pending));
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report;
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Back-to-back reads of both flag registers
    task automatic rd2(input logic [7:0] a, input logic [7:0] b);
        exp_q.push_back(a);
        host.rd(8'h26);
        exp_q.push_back(b);
        host.rd(8'h27);
        host.idle();
    endtask
    always @(negedge clk_sys) if (rd_valid === 1'b1) begin
        if (exp_q.size() == 0) check("rd_valid", 8'h01, 8'h00);
        else check("rd_data", rd_data, exp_q.pop_front());
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 2000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        void'($urandom(84438));
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        rd2(8'h00, 8'h00);
        for (int k = 0; k < 13; k++) begin
            m = (k < 8) ? 8'h80 >> k : (k < 12) ? 8'h80 >> (k - 8) : 8'h04;
            @(negedge clk_sys) ev[k] = 1'b1;
            repeat (6 + $urandom % 4) @(posedge clk_sys);
            @(negedge clk_sys);
            check("fault_pending", {7'h00, fault_pending}, 8'h01);
            ua = $urandom;
            if (ua[7:1] == 7'h13) ua = 8'h00;
            exp_q.push_back(8'h00);
            host.rd(ua);
            rd2(k < 8 ? m : 8'h00, k < 8 ? 8'h00 : m);
            rd2(8'h00, 8'h00);
            check("fault_pending", {7'h00, fault_pending}, 8'h00);
            @(negedge clk_sys) ev[k] = 1'b0;
            repeat (6) @(posedge clk_sys);
            rd2(k == 0 ? 8'h80 : 8'h00, 8'h00);
        end
        final_report();
    end
endmodule // fev_fault_event_flag_bank_bench
